// file: src/i2c_link_dev.sv
// Purpose: device end, slave address match and register access
// Assumes: reg_rdata follows reg_rd_addr well within one bit time
// Notes: holds the configuration register itself, others outside
`timescale 1ns/1ps
`default_nettype none
`include "i2c_link_map.svh"
// Notes on behaviour
// R01 - address is seven bits plus direction bit
// R02 - upper address nibble must be 0111
// R03 - strap picks address bits two and one
// R04 - watch for start plus own address, acknowledge
// R05 - abort and release data after 20 ms
// R06 - after abort wait for a fresh start
// R07 - timeout switched by a configuration bit
// R08 - first written byte is the command byte
// R09 - stop after command byte only sets pointer
// R10 - later bytes written to pointed registers
// R11 - pointer steps after each data byte
// R12 - lone command byte does not step pointer
// R13 - reads start at pointer and advance it
// R14 - master rewrites pointer before read-back
// R15 - master joins pointer write and read with restart
// R16 - host soft resets via bit 4 of 0x40; the device end only passes this write to the register port and does not reset
// R17 - receiver pulls data low on ninth clock
// R18 - start and stop are data edges, clock high
// R19 - bit 0 of register 0x01 disables timeout
// R20 - master nack ends sending until next start
// R21 - timeout never fires before 20 ms
module i2c_link_dev #(
    parameter int unsigned TIMEOUT_CYC = `TMO_CYC // cycles without scl edge
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // synchronous reset, low active
    i2c_link_if.dev bus, // two-wire bus
    input wire logic [1:0] addr_strap_input, // strap tie code
    output logic reg_wr_en, // register write, one cycle
    output logic [7:0] reg_wr_addr, // register written
    output logic [7:0] reg_wr_data, // byte written
    output logic [7:0] reg_rd_addr, // register pointer for reads
    input wire logic [7:0] reg_rdata, // contents at reg_rd_addr
    output logic tmo_enabled, // timeout currently armed by config
    output logic tmo_abort, // transfer aborted, one cycle
    output logic busy // transfer in progress from any start, own address or not
);
    import i2c_link_pkg::*;

    localparam logic [`TMO_W-1:0] TMO_LIM = TIMEOUT_CYC[`TMO_W-1:0];

    dev_regs_t r;
    dev_regs_t n;
    logic new_scl;
    logic new_sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic abort;
    logic [7:0] rd_byte;

    // own address: fixed nibble, strap code, lowest bit either value
    function automatic logic addr_match(input logic [6:0] a,
                                        input logic [1:0] strap);
        return (a[6:3] == `ADDR_FIXED) && (a[2:1] == strap);
    endfunction

    // pointer steps inside the register window, wraps at its end
    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        logic [7:0] q;
        q = p;
        if (p == `PTR_LAST) begin
            q = `PTR_FIRST;
        end else if (p >= `PTR_FIRST && p < `PTR_LAST) begin
            q = p + 8'h01;
        end
        return q;
    endfunction

    // filtered line levels, a change counts once stages two and three agree
    assign new_scl = (r.scl_sy[1] == r.scl_sy[2]) ? r.scl_sy[2] : r.scl_f;
    assign new_sda = (r.sda_sy[1] == r.sda_sy[2]) ? r.sda_sy[2] : r.sda_f;
    assign scl_rise = ~r.scl_f & new_scl;
    assign scl_fall = r.scl_f & ~new_scl;

    // bus conditions, data edge while clock stays high
    assign start_seen = r.scl_f & new_scl & r.sda_f & ~new_sda; // R18
    assign stop_seen = r.scl_f & new_scl & ~r.sda_f & new_sda; // R18

    // stalled clock while busy and timeout enabled (bit low)
    assign abort = ~r.cfg[`CFG_TMO_DIS_BIT] // R19 R07
                   & (r.st != D_IDLE) & (r.tmo >= TMO_LIM); // R05 R21

    // configuration register answers locally, the rest from outside
    assign rd_byte = (r.ptr == `CFG_REG_ADDR) ? r.cfg : reg_rdata;

    // next state of the whole device end
    always_comb begin
        n = r;
        n.wr_en = 1'b0;
        n.timeout = 1'b0;
        n.scl_sy = {r.scl_sy[1:0], bus.scl};
        n.sda_sy = {r.sda_sy[1:0], bus.sda};
        n.strap_sy = {r.strap_sy[3:0], addr_strap_input};
        n.scl_f = new_scl;
        n.sda_f = new_sda;
        if (r.strap_sy[3:2] == r.strap_sy[5:4]) begin
            n.strap = r.strap_sy[5:4];
        end
        // time since the last clock edge
        if (r.st == D_IDLE || scl_rise || scl_fall) begin
            n.tmo = '0;
        end else if (r.tmo != '1) begin
            n.tmo = r.tmo + 24'h000001;
        end
        if (start_seen) begin
            // start or repeated start always reopens address phase
            n.st = D_ADDR; // R04 R06
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (stop_seen) begin
            n.st = D_IDLE; // R09
            n.sda_oe_n = 1'b1;
        end else if (abort) begin
            n.st = D_IDLE; // R05 R06
            n.sda_oe_n = 1'b1;
            n.timeout = 1'b1;
        end else if (scl_rise) begin
            case (r.st)
                D_ADDR, D_RX: begin
                    n.sh = {r.sh[6:0], r.sda_f};
                    n.cnt = r.cnt + 4'h1;
                end
                D_TX_ACK: n.mack = ~r.sda_f; // R17
                default: ;
            endcase
        end else if (scl_fall) begin
            case (r.st)
                D_ADDR: begin
                    if (r.cnt == 4'h8) begin
                        if (addr_match(r.sh[7:1], r.strap)) begin // R02 R03
                            n.sda_oe_n = 1'b0; // R04 R17
                            n.rw = r.sh[0]; // R01
                            n.first = 1'b1;
                            n.st = D_ADDR_ACK;
                        end else begin
                            n.st = D_IDLE;
                        end
                    end
                end
                D_ADDR_ACK: begin
                    if (r.rw) begin
                        // read: first byte from the stored pointer
                        n.sh = {rd_byte[6:0], 1'b0}; // R13
                        n.sda_oe_n = rd_byte[7];
                        n.cnt = 4'h1;
                        n.ptr = next_ptr(r.ptr); // R11 R13
                        n.st = D_TX;
                    end else begin
                        n.sda_oe_n = 1'b1;
                        n.cnt = 4'h0;
                        n.st = D_RX;
                    end
                end
                D_RX: begin
                    if (r.cnt == 4'h8) begin
                        n.sda_oe_n = 1'b0; // R17
                        n.st = D_RX_ACK;
                        n.first = 1'b0;
                        if (r.first) begin
                            n.ptr = r.sh; // R08 R09 R12
                        end else begin
                            n.wr_en = 1'b1; // R10
                            n.wr_addr = r.ptr;
                            n.wr_data = r.sh;
                            if (r.ptr == `CFG_REG_ADDR) begin
                                n.cfg = r.sh; // R07
                            end
                            n.ptr = next_ptr(r.ptr); // R11
                        end
                    end
                end
                D_RX_ACK: begin
                    n.sda_oe_n = 1'b1;
                    n.cnt = 4'h0;
                    n.st = D_RX;
                end
                D_TX: begin
                    if (r.cnt == 4'h8) begin
                        n.sda_oe_n = 1'b1;
                        n.st = D_TX_ACK;
                    end else begin
                        n.sda_oe_n = r.sh[7];
                        n.sh = {r.sh[6:0], 1'b0};
                        n.cnt = r.cnt + 4'h1;
                    end
                end
                D_TX_ACK: begin
                    if (r.mack) begin
                        n.sh = {rd_byte[6:0], 1'b0}; // R13
                        n.sda_oe_n = rd_byte[7];
                        n.cnt = 4'h1;
                        n.ptr = next_ptr(r.ptr); // R11
                        n.st = D_TX;
                    end else begin
                        n.st = D_IDLE; // R20
                    end
                end
                default: n.st = D_IDLE;
            endcase
        end
        n.busy = (n.st != D_IDLE);
    end

    // state register, lines assumed idle high at reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.scl_sy <= 3'h7;
            r.sda_sy <= 3'h7;
            r.scl_f <= 1'b1;
            r.sda_f <= 1'b1;
            r.ptr <= `PTR_RESET;
            r.cfg <= `CFG_RESET;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe_n = r.sda_oe_n;
    assign reg_wr_en = r.wr_en;
    assign reg_wr_addr = r.wr_addr;
    assign reg_wr_data = r.wr_data;
    assign reg_rd_addr = r.ptr;
    assign tmo_enabled = ~r.cfg[`CFG_TMO_DIS_BIT];
    assign tmo_abort = r.timeout;
    assign busy = r.busy;
endmodule
`default_nettype wire

// file: src/i2c_link_host.sv
// Purpose: bus master end, runs start, byte and stop commands
// Assumes: one command at a time, no clock stretching by slaves
// Notes: each bit slot is four quarter ticks of the divider
`timescale 1ns/1ps
`default_nettype none
`include "i2c_link_map.svh"
module i2c_link_host #(
    parameter int unsigned QUARTER_CYC = `QTR_CYC // cycles per quarter bit
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // synchronous reset, low active
    i2c_link_if.host bus, // two-wire bus
    input wire logic cmd_valid, // command offered
    output logic cmd_ready, // command can be taken
    input wire i2c_link_pkg::host_op_t cmd_op, // start, write, read, stop
    input wire logic [7:0] cmd_data, // byte to write
    input wire logic cmd_ack, // read: acknowledge the byte
    output logic rsp_valid, // byte slot finished, one cycle
    output logic [7:0] rsp_data, // byte read from the bus
    output logic rsp_nack // ninth bit was high
);
    import i2c_link_pkg::*;

    localparam logic [`QTR_W-1:0] QLAST = QUARTER_CYC[`QTR_W-1:0] - 8'h01;
    host_regs_t r;
    host_regs_t n;
    logic tick;

    // quarter-bit enable pulse
    assign tick = (r.div == QLAST);

    // next state of the whole master
    always_comb begin
        n = r;
        n.rsp_valid = 1'b0;
        n.sda_sy = {r.sda_sy[1:0], bus.sda};
        if (r.sda_sy[1] == r.sda_sy[2]) begin
            n.sda_f = r.sda_sy[2];
        end
        n.div = (tick || r.st == H_IDLE) ? '0 : r.div + 8'h01;
        if (r.st != H_IDLE && tick) begin
            n.ph = r.ph + 2'h1;
        end
        case (r.st)
            H_IDLE: begin
                if (cmd_valid && r.ready) begin
                    n.ready = 1'b0;
                    n.ph = 2'h0;
                    n.op = cmd_op;
                    n.sh = cmd_data;
                    n.ack_out = cmd_ack;
                    n.bit_i = 4'h0;
                    case (cmd_op)
                        OP_START: n.st = H_START; // R15
                        OP_STOP: n.st = H_STOP;
                        default: n.st = H_BIT;
                    endcase
                end
            end
            H_START: begin
                // release both, then pull data low under a high clock
                if (tick) begin
                    case (r.ph)
                        2'h0: n.sda_oe_n = 1'b1;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b0; // R18
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.st = H_IDLE;
                            n.ready = 1'b1;
                        end
                    endcase
                end
            end
            H_BIT: begin
                if (tick) begin
                    case (r.ph)
                        2'h0: begin
                            if (r.bit_i != 4'h8) begin
                                n.sda_oe_n = (r.op == OP_WRITE) ? r.sh[7] : 1'b1;
                            end else begin
                                n.sda_oe_n = (r.op == OP_READ) ? ~r.ack_out
                                                               : 1'b1; // R17
                            end
                        end
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: begin
                            if (r.bit_i != 4'h8) begin
                                n.rx = {r.rx[6:0], r.sda_f};
                            end else begin
                                n.rsp_nack = r.sda_f; // R17
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.sh = {r.sh[6:0], 1'b0};
                            if (r.bit_i == 4'h8) begin
                                n.rsp_valid = 1'b1;
                                n.rsp_data = r.rx;
                                n.st = H_IDLE;
                                n.ready = 1'b1;
                            end else begin
                                n.bit_i = r.bit_i + 4'h1;
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                // data low, clock high, then data rises
                if (tick) begin
                    case (r.ph)
                        2'h0: n.sda_oe_n = 1'b0;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b1; // R18
                        default: begin
                            n.st = H_IDLE;
                            n.ready = 1'b1;
                        end
                    endcase
                end
            end
            default: n.st = H_IDLE;
        endcase
    end

    // state register, bus released at reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.sda_sy <= 3'h7;
            r.sda_f <= 1'b1;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
            r.ready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe_n = r.scl_oe_n;
    assign bus.m_sda_oe_n = r.sda_oe_n;
    assign cmd_ready = r.ready;
    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp_data;
    assign rsp_nack = r.rsp_nack;
endmodule
`default_nettype wire

// file: src/i2c_link_if.sv
// Purpose: two-wire bus joining the master end and the device end
// Assumes: both lines are open drain with a pull-up
// Notes: a line is low when any party enables its driver
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic scl;
    logic sda;
    // wired-and of the drivers, pulled high when released
    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
    modport host (
        input scl, sda,
        output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n
    );
    modport dev (
        input scl, sda,
        output d_sda_o, d_sda_oe_n
    );
endinterface
`default_nettype wire

// file: src/i2c_link_map.svh
// Purpose: constants shared by both ends of the two-wire link
// Assumes: core_clk runs at 125 MHz
// Notes: guarded, included by the package and by each end
`ifndef I2C_LINK_MAP_SVH
`define I2C_LINK_MAP_SVH
`define CLK_PERIOD_NS 8
// fixed upper address nibble, strap codes for address bits 2:1
`define ADDR_FIXED 4'h7
`define STRAP_GND 2'h0
`define STRAP_VCC 2'h1
`define STRAP_SDA 2'h2
`define STRAP_SCL 2'h3
// register pointer window and configuration register
`define PTR_FIRST 8'h31
`define PTR_LAST 8'h5B
`define PTR_RESET 8'h00
`define CFG_REG_ADDR 8'h01
`define CFG_RESET 8'h0A
`define CFG_TMO_DIS_BIT 0
`define SWRST_REG_ADDR 8'h40
`define SWRST_BIT 4
// bus timeout, least time rounds up to whole cycles
`define TMO_NS 20000000
`define TMO_CYC ((`TMO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMO_W 24
// quarter of a 400 kbit/s bit period, rounded up
`define QTR_NS 625
`define QTR_CYC ((`QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QTR_W 8
`endif

// file: src/i2c_link_pkg.sv
// Purpose: types shared by both ends of the two-wire link
// Assumes: i2c_link_map.svh holds the numeric constants
// Notes: state of each end is one packed struct
`include "i2c_link_map.svh"
package i2c_link_pkg;
    typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} host_op_t;
    typedef enum logic [2:0] {
        D_IDLE, D_ADDR, D_ADDR_ACK, D_RX, D_RX_ACK, D_TX, D_TX_ACK
    } dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
    typedef struct packed {
        dev_state_t st;
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [5:0] strap_sy;
        logic scl_f;
        logic sda_f;
        logic [1:0] strap;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic mack;
        logic [7:0] ptr;
        logic [7:0] cfg;
        logic [`TMO_W-1:0] tmo;
        logic sda_oe_n;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic timeout;
        logic busy;
    } dev_regs_t;
    typedef struct packed {
        host_state_t st;
        logic [`QTR_W-1:0] div;
        logic [1:0] ph;
        logic [3:0] bit_i;
        host_op_t op;
        logic [7:0] sh;
        logic [7:0] rx;
        logic ack_out;
        logic [2:0] sda_sy;
        logic sda_f;
        logic scl_oe_n;
        logic sda_oe_n;
        logic ready;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_nack;
    } host_regs_t;
endpackage

// file: verification/i2c_link_properties.sv
// Purpose: timing properties of the two-wire link between both ends
// Assumes: one clock domain, every signal sampled on core_clk
// Notes: instantiated by tb beside the interface, no bind
`timescale 1ns/1ps
`default_nettype none
module i2c_link_checker #(
    parameter int unsigned TIMEOUT_CYC = 2500000 // device timeout count
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // sync reset, low active
    input wire logic scl, // resolved clock line
    input wire logic sda, // resolved data line
    input wire logic d_sda_oe_n, // device data drive, low active
    input wire logic busy, // device transfer active
    input wire logic tmo_abort, // device abort pulse
    input wire logic tmo_enabled, // timeout armed
    input wire logic reg_wr_en, // register write strobe
    input wire logic [7:0] reg_wr_addr, // register written
    input wire logic [7:0] reg_rd_addr // device pointer
);
    localparam int TO_MIN = int'(TIMEOUT_CYC);
    localparam int TO_MAX = int'(TIMEOUT_CYC) + 16;
    logic scl_q;
    logic [23:0] idle_cnt;
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // cycles since the last clock line edge, saturating
    always_ff @(posedge core_clk) begin
        scl_q <= scl;
        if (!rst_n || scl != scl_q) begin
            idle_cnt <= 24'h000000;
        end else if (idle_cnt != 24'hFFFFFF) begin
            idle_cnt <= idle_cnt + 24'h000001;
        end
    end
    // pointer after one burst step, wraps inside the window
    function automatic logic [7:0] step(input logic [7:0] p);
        if (p == 8'h5B) return 8'h31;
        if (p >= 8'h31 && p < 8'h5B) return p + 8'h01;
        return p;
    endfunction
    AST_DEV_HOLD: assert property (scl && $past(scl) && !tmo_abort
        |-> $stable(d_sda_oe_n)) else $error("device data moved, clock high");
    AST_DRIVE_LOW: assert property ($fell(d_sda_oe_n) |-> !scl)
        else $error("device drive began with clock high");
    AST_TMO_FREE: assert property (tmo_abort |-> d_sda_oe_n && !busy)
        else $error("abort left device busy or driving");
    AST_TMO_QUIET: assert property (tmo_abort |=> d_sda_oe_n [*8])
        else $error("device drove data right after abort");
    AST_TMO_EARLY: assert property (tmo_abort |-> idle_cnt >= TO_MIN)
        else $error("abort came too early");
    AST_TMO_BOUND: assert property (tmo_enabled && busy
        |-> idle_cnt <= TO_MAX) else $error("stalled transfer not aborted");
    AST_TMO_OFF: assert property (!$past(tmo_enabled) |-> !tmo_abort)
        else $error("abort while timeout disabled");
    AST_WR_ACK: assert property (reg_wr_en |-> ##[0:8] !d_sda_oe_n)
        else $error("written byte not acknowledged");
    AST_WR_STEP: assert property (reg_wr_en
        |-> ##[0:2] reg_rd_addr == step(reg_wr_addr))
        else $error("pointer did not step after write");
    AST_STOP_IDLE: assert property (scl && $past(scl) && $rose(sda)
        |-> ##[0:8] !busy) else $error("device busy after stop");
    // main scenarios reached
    cover property (tmo_abort);
    cover property (reg_wr_en && reg_wr_addr == 8'h31);
    cover property ($fell(busy));
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: self-checking bench, master end driving the device end
// Assumes: short quarter and timeout counts keep the run brief
// Notes: a small register array answers the device register port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import i2c_link_pkg::*;
    localparam int Q = 10;
    localparam int TO = 2000;
    localparam logic [7:0] WA = 8'h74; // strap code 1, write
    localparam logic [7:0] RA = 8'h75; // strap code 1, read
    logic core_clk, rst_n, cmd_valid, cmd_ready, cmd_ack;
    logic rsp_valid, rsp_nack, reg_wr_en, tmo_enabled, tmo_abort, busy;
    host_op_t cmd_op;
    logic [7:0] cmd_data, rsp_data, reg_wr_addr, reg_wr_data;
    logic [7:0] reg_rd_addr, reg_rdata;
    logic [1:0] addr_strap_input;
    logic [7:0] mem [256];
    int errors = 0;
    int checks = 0;
    int aborts = 0;
    int writes = 0;
    i2c_link_if i2c_link_if_i ();
    i2c_link_host #(.QUARTER_CYC(Q)) i2c_link_host_i (
        .core_clk(core_clk), .rst_n(rst_n), .bus(i2c_link_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    i2c_link_dev #(.TIMEOUT_CYC(TO)) i2c_link_dev_i (
        .core_clk(core_clk), .rst_n(rst_n), .bus(i2c_link_if_i),
        .addr_strap_input(addr_strap_input), .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata),
        .tmo_enabled(tmo_enabled), .tmo_abort(tmo_abort), .busy(busy));
    i2c_link_checker #(.TIMEOUT_CYC(TO)) i2c_link_checker_i (
        .core_clk(core_clk), .rst_n(rst_n), .scl(i2c_link_if_i.scl),
        .sda(i2c_link_if_i.sda), .d_sda_oe_n(i2c_link_if_i.d_sda_oe_n),
        .busy(busy), .tmo_abort(tmo_abort), .tmo_enabled(tmo_enabled),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_rd_addr(reg_rd_addr));
    always #4 core_clk = ~core_clk;
    // register array behind the device, counts strobes and aborts
    assign reg_rdata = mem[reg_rd_addr];
    always @(posedge core_clk) begin
        if (reg_wr_en === 1'b1) begin
            mem[reg_wr_addr] <= reg_wr_data;
            writes++;
        end
        if (tmo_abort === 1'b1) aborts++;
    end
    task automatic close_out();
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one master command, returns once the master is ready again
    task automatic op(input host_op_t o, input logic [7:0] d,
                      input logic a);
        cmd_op = o;
        cmd_data = d;
        cmd_ack = a;
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        for (int n = 0; n < 2000 && cmd_ready !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        // ready back in time, write and read slots end with a pulse
        chk({6'h00, cmd_ready, rsp_valid}, {7'h01, o[1] ^ o[0]});
    endtask
    task automatic wbyte(input logic [7:0] d, input logic nk);
        op(OP_WRITE, d, 1'b0);
        chk({7'h00, rsp_nack}, {7'h00, nk});
    endtask
    task automatic rbyte(input logic [7:0] e, input logic ak);
        op(OP_READ, 8'h00, ak);
        chk(rsp_data, e);
    endtask
    task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
        op(OP_START, 8'h00, 1'b0);
        wbyte(WA, 1'b0);
        wbyte(r, 1'b0);
        wbyte(d, 1'b0);
        op(OP_STOP, 8'h00, 1'b0);
    endtask
    // every strap code against matching and foreign addresses
    task automatic t_addr();
        logic [7:0] a;
        for (int s = 0; s < 4; s++) begin
            addr_strap_input = 2'(s);
            for (int t = 0; t < 4; t++) begin
                a = {(t == 3) ? 4'h6 : 4'h7, 2'(s + (t == 2)), t[0], 1'b0};
                op(OP_START, 8'h00, 1'b0);
                wbyte(a, t >= 2);
                op(OP_STOP, 8'h00, 1'b0);
            end
        end
        chk({6'h00, i2c_link_if_i.scl, i2c_link_if_i.sda}, 8'h03);
    endtask
    // burst write across the window end
    task automatic t_burst();
        op(OP_START, 8'h00, 1'b0);
        wbyte(WA, 1'b0);
        chk(rsp_data, WA);
        wbyte(8'h5A, 1'b0);
        wbyte(8'h11, 1'b0);
        wbyte(8'h22, 1'b0);
        wbyte(8'h33, 1'b0);
        op(OP_STOP, 8'h00, 1'b0);
        chk(mem[8'h5A], 8'h11);
        chk(mem[8'h5B], 8'h22);
        chk(mem[8'h31], 8'h33);
        chk(reg_rd_addr, 8'h32);
    endtask
    // lone command byte then stop
    task automatic t_cmd_only();
        int w0;
        w0 = writes;
        op(OP_START, 8'h00, 1'b0);
        wbyte(WA, 1'b0);
        wbyte(8'h31, 1'b0);
        op(OP_STOP, 8'h00, 1'b0);
        chk(reg_rd_addr, 8'h31);
        chk(8'(writes - w0), 8'h00);
    endtask
    // pointer set, repeated start, burst read ending in a nack
    task automatic t_read();
        op(OP_START, 8'h00, 1'b0);
        wbyte(WA, 1'b0);
        wbyte(8'h5A, 1'b0);
        op(OP_START, 8'h00, 1'b0);
        wbyte(RA, 1'b0);
        rbyte(8'h11, 1'b1);
        rbyte(8'h22, 1'b1);
        rbyte(8'h33, 1'b0);
        chk({7'h00, i2c_link_if_i.d_sda_oe_n}, 8'h01);
        op(OP_STOP, 8'h00, 1'b0);
        chk(reg_rd_addr, 8'h32);
    endtask
    // master stalls after the address, abort expected unless the timeout is disabled
    task automatic t_timeout(input logic off);
        int n0;
        n0 = aborts;
        op(OP_START, 8'h00, 1'b0);
        wbyte(WA, 1'b0);
        repeat (TO + 100) @(posedge core_clk);
        #1;
        chk(8'(aborts - n0), {7'h00, !off});
        chk({7'h00, busy}, {7'h00, off});
        wbyte(8'h31, !off);
        op(OP_STOP, 8'h00, 1'b0);
    endtask
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_START;
        cmd_data = 8'h00;
        cmd_ack = 1'b0;
        addr_strap_input = 2'h0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        chk({5'h00, cmd_ready, tmo_enabled, busy}, 8'h06);
        t_addr();
        addr_strap_input = 2'h1;
        t_burst();
        t_cmd_only();
        t_read();
        wr_reg(8'h40, 8'h10);
        chk(mem[8'h40], 8'h10);
        t_timeout(1'b0);
        wr_reg(8'h01, 8'h0B);
        chk({7'h00, tmo_enabled}, 8'h00);
        t_timeout(1'b1);
        wr_reg(8'h01, 8'h0A);
        chk({7'h00, tmo_enabled}, 8'h01);
        close_out();
    end
    // cut a hang short
    initial begin
        repeat (40000) @(posedge core_clk);
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
